// ==== bench/pia_core_model.sv ====
// pia_core_model: processor core and request sources facing the arbiter
// assumes the bench calls fire() from one process only
`timescale 1ns/10ps
module pia_core_model
	(
	// clock
	input  wire logic        clk,
	// events towards the arbiter
	output logic      [15:0] src_req,
	output logic      [2:0]  external_request_pin,
	output logic             opcode_fetch,
	output logic             break_trap,
	output logic             zero_div_trap,
	output logic             wdog_req
	);
	initial
	begin
		{src_req, external_request_pin, opcode_fetch} = '0;
		{break_trap, zero_div_trap, wdog_req} = '0;
	end
	// every event is a one-cycle pulse, so a fetch is never held into a busy detection
	task automatic fire(input logic f, input logic [2:0] t, input logic [15:0] s);
		@(posedge clk);
		opcode_fetch <= f;
		{break_trap, zero_div_trap, wdog_req} <= t;
		src_req <= s;
		@(posedge clk);
		opcode_fetch <= 1'b0;
		{break_trap, zero_div_trap, wdog_req} <= 3'h0;
		src_req <= 16'h0;
	endtask
	// pin levels change right after an edge, like every other event
	task automatic set_pins(input logic [2:0] p);
		external_request_pin <= p;
	endtask
endmodule // pia_core_model

// ==== bench/tb_top.sv ====
// tb_top: self-checking bench, pia_arbiter against an integer model
// assumes the core model drives every event input; registers over avalon-mm
`timescale 1ns/10ps
module tb_top;
	logic        clk, rstn, rd, wr, wreq, fetch, btrap, zdiv, wdog, acc;
	logic [7:0]  adr;
	logic [31:0] wd, rdata, v, c;
	logic [15:0] sreq, m;
	logic [2:0]  pins, alvl, wl;
	logic [4:0]  asrc, ws;
	int          failures, n_checks, seed, mask, det, ppl, sense, n, t0;
	int          pend[16];
	int          lvl[16];
	int          dl[4];

	pia_core_model core
	(
		.clk                  (clk),
		.src_req              (sreq),
		.external_request_pin (pins),
		.opcode_fetch         (fetch),
		.break_trap           (btrap),
		.zero_div_trap        (zdiv),
		.wdog_req             (wdog)
	);

	pia_arbiter DUT
	(
		.clk                  (clk),
		.rstn                 (rstn),
		.avs_address          (adr),
		.avs_read             (rd),
		.avs_write            (wr),
		.avs_writedata        (wd),
		.avs_readdata         (rdata),
		.avs_waitrequest      (wreq),
		.src_req              (sreq),
		.external_request_pin (pins),
		.opcode_fetch         (fetch),
		.break_trap           (btrap),
		.zero_div_trap        (zdiv),
		.wdog_req             (wdog),
		.irq_accept           (acc),
		.irq_src              (asrc),
		.irq_level            (alvl)
	);

	always #50 clk = ~clk;

	task automatic wrap_up;
		if (failures == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string s);
		n_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("ERROR %0t %s got %h exp %h", $time, s, got, exp);
		end
	endtask

	// request held until the edge that sees waitrequest low
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clk);
		adr <= a;
		wr <= w;
		rd <= !w;
		wd <= d;
		k = 0;
		do
		begin
			@(posedge clk);
			k++;
		end
		while (wreq !== 1'b0 && k < 20);
		if (wreq !== 1'b0)
		begin
			failures++;
			wrap_up();
		end
		if (!w)
			v = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask

	// counts accept pulses over a fixed window, keeps the first one
	task automatic waitacc(input int lim);
		n = 0;
		t0 = 0;
		for (int k = 1; k <= lim; k++)
		begin
			@(posedge clk);
			if (acc === 1'b1)
			begin
				n++;
				if (n == 1)
				begin
					t0 = k;
					ws = asrc;
					wl = alvl;
				end
			end
		end
	endtask

	// chain from converter down, strict compare
	function automatic int win(output int lv);
		int p;
		win = 31;
		lv = 0;
		for (int i = 15; i >= 0; i--)
		begin
			p = (i < 3 && sense[i]) ? int'(pins[i]) : pend[i];
			if (p != 0 && lvl[i] > lv)
			begin
				win = i;
				lv = lvl[i];
			end
		end
	endfunction

	function automatic logic [31:0] pm();
		pm = 0;
		for (int i = 0; i < 16; i++)
			pm[i] = pend[i][0];
	endfunction

	// x > 0 adds a second fetch and a new request while detecting
	task automatic detect(input int x);
		int s, l, ex;
		s = win(l);
		ex = mask == 0 && s != 31 && l > ppl;
		core.fire(1'b1, 3'h0, 16'h0);
		if (x > 0)
			core.fire(1'b1, 3'h0, 16'h1 << (x % 16));
		if (x > 0)
			pend[x % 16] = 1;
		waitacc(12);
		chk(n, ex, "accept count");
		if (ex != 0)
		begin
			chk(ws, s, "winner");
			chk(wl, l, "level");
			if (x == 0)
				chk(t0, dl[det] + 2, "latency");
			// a new request landing on the accepting edge beats the clear
			pend[s] = (x > 0 && s == x % 16 && dl[det] == 1) ? 1 : 0;
			ppl = l;
		end
	endtask

	initial
	begin
		#(100 * 90000);
		failures++;
		wrap_up();
	end

	initial
	begin
		clk = 1'b0;
		rstn = 1'b0;
		{adr, rd, wr, wd} = '0;
		seed = 32'h96E39F6E;
		failures = 0;
		n_checks = 0;
		mask = 1;
		det = 1;
		ppl = 0;
		sense = 0;
		pend = '{default: 0};
		lvl = '{default: 0};
		dl = '{pia_pkg::DET_CYC_0, pia_pkg::DET_CYC_1, pia_pkg::DET_CYC_2, pia_pkg::DET_CYC_3};
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		chk(asrc, pia_pkg::SRC_NONE, "idle src");
		bus(0, pia_pkg::ADR_CTRL, 0);
		chk(v, 32'h0000_0003, "ctrl reset");
		bus(0, 8'hF0, 0);
		chk(v, pia_pkg::RD_UNMAPPED, "unmapped");
		bus(0, pia_pkg::ADR_PEND, 0);
		chk(v, 0, "pend reset");
		for (int it = 0; it < 40; it++)
		begin
			v = $random(seed);
			for (int i = 0; i < 16; i++)
				lvl[i] = (i < 8) ? v[3 * i +: 3] : lvl[i];
			bus(1, pia_pkg::ADR_LVL_LO, v);
			v = $random(seed);
			for (int i = 0; i < 8; i++)
				lvl[8 + i] = v[3 * i +: 3];
			bus(1, pia_pkg::ADR_LVL_HI, v);
			v = $random(seed);
			sense = v[2:0];
			core.set_pins(v[5:3]);
			bus(1, pia_pkg::ADR_SENSE, 32'(v[2:0]));
			v = $random(seed);
			for (int i = 0; i < 16; i++)
				pend[i] = v[16 + i] ? int'(v[0]) : pend[i];
			bus(1, v[0] ? pia_pkg::ADR_SET : pia_pkg::ADR_CLR, 32'(v[31:16]));
			v = $random(seed);
			m = v[15:0] & v[31:16];
			for (int i = 0; i < 16; i++)
				pend[i] = m[i] ? 1 : pend[i];
			core.fire(1'b0, 3'h0, m);
			v = $random(seed);
			mask = v[1:0] == 2'h0;
			det = v[3:2];
			ppl = v[6:4];
			c = {21'h0, v[6:4], 5'h0, v[3:2], v[1:0] == 2'h0};
			bus(1, pia_pkg::ADR_CTRL, c);
			bus(0, pia_pkg::ADR_CTRL, 0);
			chk(v, c, "ctrl");
			bus(0, pia_pkg::ADR_PEND, 0);
			chk(v & ~sense, pm() & ~sense, "pending");
			detect(it % 3 == 0 ? it + 1 : 0);
			bus(0, pia_pkg::ADR_CTRL, 0);
			chk(v[10:8], ppl, "level after");
		end
		// traps taken with mask set and level zero
		bus(1, pia_pkg::ADR_CTRL, 32'h0000_0003);
		for (int t = 0; t < 3; t++)
		begin
			core.fire(1'b0, 3'h4 >> t, 16'h0);
			waitacc(4);
			chk(n, 1, "trap taken");
			c = t == 0 ? pia_pkg::SRC_BREAK : t == 1 ? pia_pkg::SRC_ZDIV : pia_pkg::SRC_WDOG;
			chk(ws, c, "trap src");
			bus(0, pia_pkg::ADR_CTRL, 0);
			chk(v[10:8], t == 2 ? 7 : 0, "trap level");
		end
		wrap_up();
	end
endmodule // tb_top

// ==== verilog/pia_arbiter.sv ====
// pia_arbiter: maskable interrupt arbitration with a comparator chain
// assumes request pulses and fetch strobes come from logic on clk
// How it works
// - request flag set on event, cleared at accept
// - software sets or clears single request flags
// - level-sensed pins ignore the stored flag
// - three-bit level per source, zero disables
// - enabled only when level above processor level
// - processor level seven blocks all maskable sources
// - processor level lives in status bits 8-10
// - accept needs mask clear, flag, higher level
// - mask, flags, levels, processor level independent
// - simultaneous requests accepted highest first
// - sixteen programmable, traps and watchdog fixed
// - software traps always taken; code loses a trap to a same-cycle watchdog, and zero divide to break
// - chain from zero passes the higher level
// - ties keep the earlier stage value
// - unaccepted requests stay pending
// - detection starts at fetch, not while busy
// - flags and levels latched at detection start
// - selectable detection wait, two cycles default
// - mask flag set at reset
// - watchdog sets level seven, reset level zero
//
// Local design decisions: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/10ps
module pia_arbiter
	#(parameter int unsigned NSRC = pia_pkg::NUM_SRC)
	(
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rstn,
	// avalon-mm slave
	input  wire logic [7:0]       avs_address,
	input  wire logic             avs_read,
	input  wire logic             avs_write,
	input  wire logic [31:0]      avs_writedata,
	output logic      [31:0]      avs_readdata,
	output logic                  avs_waitrequest,
	// peripheral requests, one-cycle pulses; index 0 is pin 0, 15 the converter
	input  wire logic [NSRC-1:0]  src_req,
	// live level of the external request pins, active high after polarity
	input  wire logic [2:0]       external_request_pin,
	// core events
	input  wire logic             opcode_fetch,
	input  wire logic             break_trap,
	input  wire logic             zero_div_trap,
	input  wire logic             wdog_req,
	// acceptance towards the core
	output logic                  irq_accept,
	output logic      [4:0]       irq_src,
	output logic      [2:0]       irq_level
	);

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	logic [NSRC-1:0]   pend_q;
	logic [NSRC*3-1:0] lvl_q;
	logic              mask_q;
	logic [1:0]        det_sel_q;
	logic [2:0]        ppl_q;
	logic [2:0]        ext_sense_q;
	logic [2:0]        ext_s1_q;
	logic [2:0]        ext_s2_q;
	logic [NSRC-1:0]   snap_req_q;
	logic [NSRC*3-1:0] snap_lvl_q;
	logic [2:0]        det_cnt_q;
	pia_pkg::pia_state_t st_q;
	logic              acc_now;
	logic [4:0]        acc_src;
	logic [2:0]        acc_lvl;

	wire logic bus_wr = avs_write && !avs_waitrequest;
	wire logic bus_rd = avs_read && !avs_waitrequest;

	// ---------------------------------------------------------------
	// external pin synchroniser
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			ext_s1_q <= 3'h0;
			ext_s2_q <= 3'h0;
		end
		else
		begin
			ext_s1_q <= external_request_pin;
			ext_s2_q <= ext_s1_q;
		end
	end

	// ---------------------------------------------------------------
	// request flags
	// ---------------------------------------------------------------
	// set wins over both the software clear and the acceptance clear,
	// so an event landing in the clearing cycle is never lost
	genvar gi;
	generate
		for (gi = 0; gi < NSRC; gi++)
		begin : g_flag
			always_ff @(posedge clk or negedge rstn)
			begin
				if (!rstn)
					pend_q[gi] <= 1'b0;
				else if (src_req[gi])
					pend_q[gi] <= 1'b1;
				else if (bus_wr && avs_address == pia_pkg::ADR_SET && avs_writedata[gi])
					pend_q[gi] <= 1'b1;
				else if (bus_wr && avs_address == pia_pkg::ADR_CLR && avs_writedata[gi])
					pend_q[gi] <= 1'b0;
				else if (acc_now && acc_src == 5'(gi))
					pend_q[gi] <= 1'b0;
			end
		end
	endgenerate

	// ---------------------------------------------------------------
	// levels, mask, detection select, sense mode
	// ---------------------------------------------------------------
	// each register written alone, no cross effects
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			lvl_q <= '0;
		else if (bus_wr && avs_address == pia_pkg::ADR_LVL_LO)
			lvl_q[23:0] <= avs_writedata[23:0];
		else if (bus_wr && avs_address == pia_pkg::ADR_LVL_HI)
			lvl_q[NSRC*3-1:24] <= avs_writedata[NSRC*3-25:0];
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			mask_q    <= 1'b1;
			det_sel_q <= pia_pkg::DET_SEL_RST;
		end
		else if (bus_wr && avs_address == pia_pkg::ADR_CTRL)
		begin
			mask_q    <= avs_writedata[pia_pkg::CTRL_MASK];
			det_sel_q <= avs_writedata[pia_pkg::CTRL_DET_HI:pia_pkg::CTRL_DET_LO];
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			ext_sense_q <= 3'h0;
		else if (bus_wr && avs_address == pia_pkg::ADR_SENSE)
			ext_sense_q <= avs_writedata[2:0];
	end

	// processor level: software writes the status word field,
	// acceptance replaces it with the winner's level
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			ppl_q <= pia_pkg::LVL_ZERO;
		else if (wdog_req)
			ppl_q <= pia_pkg::LVL_TOP;
		else if (acc_now)
			ppl_q <= acc_lvl;
		// field in bits 8..10 of the status word
		else if (bus_wr && avs_address == pia_pkg::ADR_CTRL)
			ppl_q <= avs_writedata[pia_pkg::CTRL_LVL_HI:pia_pkg::CTRL_LVL_LO];
	end

	// ---------------------------------------------------------------
	// detection sequencer
	// ---------------------------------------------------------------
	logic [2:0] det_len;
	always_comb
	begin
		unique case (det_sel_q)
			2'h0: det_len = pia_pkg::DET_CYC_0;
			2'h1: det_len = pia_pkg::DET_CYC_1;
			2'h2: det_len = pia_pkg::DET_CYC_2;
			2'h3: det_len = pia_pkg::DET_CYC_3;
		endcase
	end

	logic [NSRC-1:0] live_req;
	generate
		for (gi = 0; gi < NSRC; gi++)
		begin : g_live
			if (gi < pia_pkg::NUM_EXT)
			begin : g_ext
				// level sense reads the pin, not the flag
				assign live_req[gi] = ext_sense_q[gi] ? ext_s2_q[gi] : pend_q[gi];
			end
			else
			begin : g_int
				assign live_req[gi] = pend_q[gi];
			end
		end
	endgenerate

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			st_q       <= pia_pkg::PIA_IDLE;
			det_cnt_q  <= 3'h0;
			snap_req_q <= '0;
			snap_lvl_q <= '0;
		end
		else
		begin
			unique case (st_q)
				pia_pkg::PIA_IDLE:
					// start only at a fetch when idle
					if (opcode_fetch)
					begin
						snap_req_q <= live_req;
						snap_lvl_q <= lvl_q;
						det_cnt_q  <= det_len;
						st_q       <= pia_pkg::PIA_WAIT;
					end
				pia_pkg::PIA_WAIT:
					if (det_cnt_q == 3'h1)
						st_q <= pia_pkg::PIA_DONE;
					else
						det_cnt_q <= det_cnt_q - 3'h1;
				pia_pkg::PIA_DONE:
					st_q <= pia_pkg::PIA_IDLE;
				default:
					st_q <= pia_pkg::PIA_IDLE;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// comparator chain
	// ---------------------------------------------------------------
	pia_pkg::pia_cand_t chain [NSRC+1];
	assign chain[0] = '{hit: 1'b0, lvl: pia_pkg::LVL_ZERO, src: pia_pkg::SRC_NONE};
	generate
		for (gi = 0; gi < NSRC; gi++)
		begin : g_cmp
			// stage 0 serves the converter, the last stage pin 0
			localparam int unsigned SIDX = NSRC - 1 - gi;
			wire logic [2:0] my_lvl = snap_lvl_q[SIDX*3 +: 3];
			// pass higher of own and incoming level
			// strict compare keeps earlier on ties; level zero never wins
			assign chain[gi+1] = (snap_req_q[SIDX] && my_lvl > chain[gi].lvl)
				? '{hit: 1'b1, lvl: my_lvl, src: 5'(SIDX)} : chain[gi];
		end
	endgenerate
	// the converter enters the chain first, so on equal levels it beats
	// every later stage and pin 0 loses to all of them

	// accept only the winner, one per detection
	// a trap in the same cycle owns the outputs, so the winner stays pending
	assign acc_now = st_q == pia_pkg::PIA_DONE && !mask_q && chain[NSRC].hit
		&& chain[NSRC].lvl > ppl_q && !wdog_req
		&& !break_trap && !zero_div_trap;
	assign acc_src = chain[NSRC].src;
	assign acc_lvl = chain[NSRC].lvl;

	// ---------------------------------------------------------------
	// acceptance outputs
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			irq_accept <= 1'b0;
			irq_src    <= pia_pkg::SRC_NONE;
			irq_level  <= pia_pkg::LVL_ZERO;
		end
		else if (wdog_req)
		begin
			irq_accept <= 1'b1;
			irq_src    <= pia_pkg::SRC_WDOG;
			irq_level  <= pia_pkg::LVL_TOP;
		end
		else if (break_trap || zero_div_trap)
		begin
			irq_accept <= 1'b1;
			irq_src    <= break_trap ? pia_pkg::SRC_BREAK : pia_pkg::SRC_ZDIV;
			irq_level  <= ppl_q;
		end
		else
		begin
			irq_accept <= acc_now;
			irq_src    <= acc_now ? acc_src : pia_pkg::SRC_NONE;
			irq_level  <= acc_now ? acc_lvl : pia_pkg::LVL_ZERO;
		end
	end

	// ---------------------------------------------------------------
	// bus read side, one wait cycle per access
	// ---------------------------------------------------------------
	logic wait_q;
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			wait_q <= 1'b1;
		else
			wait_q <= !((avs_read || avs_write) && wait_q);
	end
	assign avs_waitrequest = wait_q;

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			avs_readdata <= 32'h0;
		else if (avs_read && wait_q)
		begin
			unique case (avs_address)
				pia_pkg::ADR_PEND:   avs_readdata <= 32'(pend_q);
				pia_pkg::ADR_LVL_LO: avs_readdata <= {8'h0, lvl_q[23:0]};
				pia_pkg::ADR_LVL_HI: avs_readdata <= 32'(lvl_q[NSRC*3-1:24]);
				pia_pkg::ADR_CTRL:   avs_readdata <= {21'h0, ppl_q, 5'h0, det_sel_q, mask_q};
				pia_pkg::ADR_STAT:   avs_readdata <= {22'h0, st_q, ext_s2_q, acc_src};
				pia_pkg::ADR_SENSE:  avs_readdata <= {29'h0, ext_sense_q};
				default:             avs_readdata <= pia_pkg::RD_UNMAPPED;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	a_mask_blocks: assert property (@(posedge clk) disable iff (!rstn)
		(acc_now |-> !mask_q)) else $error("accept while masked");
	a_level_above: assert property (@(posedge clk) disable iff (!rstn)
		(acc_now |-> acc_lvl > ppl_q)) else $error("accept at or below level");
	a_flag_clears: assert property (@(posedge clk) disable iff (!rstn)
		(acc_now && !src_req[acc_src[3:0]] |=> !pend_q[$past(acc_src[3:0])]))
		else $error("flag kept after accept");
	a_det_wait: assert property (@(posedge clk) disable iff (!rstn)
		(st_q == pia_pkg::PIA_IDLE && opcode_fetch && det_sel_q == 2'h1
		|=> st_q == pia_pkg::PIA_WAIT ##1 st_q == pia_pkg::PIA_WAIT
		##1 st_q == pia_pkg::PIA_DONE)) else $error("detection time wrong");
	a_no_restart: assert property (@(posedge clk) disable iff (!rstn)
		(st_q == pia_pkg::PIA_WAIT |=> $stable(snap_req_q) && $stable(snap_lvl_q)))
		else $error("snapshot changed in detection");
	a_wdog_level: assert property (@(posedge clk) disable iff (!rstn)
		(wdog_req |=> ppl_q == pia_pkg::LVL_TOP && irq_accept)) else $error("watchdog level");
	a_trap_taken: assert property (@(posedge clk) disable iff (!rstn)
		(break_trap |=> irq_accept)) else $error("trap not taken");
	a_accept_ppl: assert property (@(posedge clk) disable iff (!rstn)
		(acc_now && !wdog_req |=> irq_accept && ppl_q == irq_level))
		else $error("level not loaded");
	a_top_blocks: assert property (@(posedge clk) disable iff (!rstn)
		(ppl_q == pia_pkg::LVL_TOP |-> !acc_now)) else $error("level seven leaked");
	a_trap_source: assert property (@(posedge clk) disable iff (!rstn)
		(break_trap && !wdog_req |=> irq_src == pia_pkg::SRC_BREAK))
		else $error("break trap source wrong");
	a_wdog_source: assert property (@(posedge clk) disable iff (!rstn)
		(wdog_req |=> irq_src == pia_pkg::SRC_WDOG))
		else $error("watchdog source wrong");
	a_busy_no_start: assert property (@(posedge clk) disable iff (!rstn)
		(st_q == pia_pkg::PIA_DONE |=> st_q == pia_pkg::PIA_IDLE))
		else $error("detection restarted while busy");
	a_zero_level: assert property (@(posedge clk) disable iff (!rstn)
		(acc_now |-> acc_lvl != pia_pkg::LVL_ZERO))
		else $error("level zero accepted");
endmodule // pia_arbiter

// ==== verilog/pia_pkg.sv ====
// pia_pkg: constants, types and register map of the priority interrupt arbiter
// assumes a single 10 MHz clock domain; registers reached over Avalon-MM
package pia_pkg;
	// ---------------------------------------------------------------
	// sources and levels
	// ---------------------------------------------------------------
	localparam int unsigned NUM_SRC    = 16;
	localparam int unsigned LVL_W      = 3;
	localparam int unsigned NUM_EXT    = 3;
	localparam logic [2:0]  LVL_ZERO   = 3'h0;
	localparam logic [2:0]  LVL_TOP    = 3'h7;
	localparam int unsigned PSW_LVL_LO = 8;
	localparam int unsigned PSW_LVL_HI = 10;
	localparam logic [4:0]  SRC_NONE   = 5'h1F;
	localparam logic [4:0]  SRC_WDOG   = 5'h10;
	localparam logic [4:0]  SRC_BREAK  = 5'h11;
	localparam logic [4:0]  SRC_ZDIV   = 5'h12;

	// ---------------------------------------------------------------
	// detection time in phi cycles
	// ---------------------------------------------------------------
	localparam logic [1:0]  DET_SEL_RST = 2'h1;
	localparam logic [2:0]  DET_CYC_0   = 3'h1;
	localparam logic [2:0]  DET_CYC_1   = 3'h2;
	localparam logic [2:0]  DET_CYC_2   = 3'h4;
	localparam logic [2:0]  DET_CYC_3   = 3'h6;

	// ---------------------------------------------------------------
	// register map, byte addresses
	// ---------------------------------------------------------------
	localparam logic [7:0]  ADR_PEND   = 8'h00;
	localparam logic [7:0]  ADR_SET    = 8'h04;
	localparam logic [7:0]  ADR_CLR    = 8'h08;
	localparam logic [7:0]  ADR_LVL_LO = 8'h0C;
	localparam logic [7:0]  ADR_LVL_HI = 8'h10;
	localparam logic [7:0]  ADR_CTRL   = 8'h14;
	localparam logic [7:0]  ADR_STAT   = 8'h18;
	localparam logic [7:0]  ADR_SENSE  = 8'h1C;
	localparam logic [31:0] RD_UNMAPPED = 32'hDEAD_BEEF;
	localparam int unsigned CTRL_MASK  = 0;
	localparam int unsigned CTRL_DET_LO = 1;
	localparam int unsigned CTRL_DET_HI = 2;
	localparam int unsigned CTRL_LVL_LO = 8;
	localparam int unsigned CTRL_LVL_HI = 10;
	localparam logic [31:0] PSW_RST    = 32'h0000_0001;

	typedef enum logic [1:0] {
		PIA_IDLE = 2'b00,
		PIA_WAIT = 2'b01,
		PIA_DONE = 2'b10
	} pia_state_t;

	// winner carried along the comparator chain
	typedef struct packed {
		logic       hit;
		logic [2:0] lvl;
		logic [4:0] src;
	} pia_cand_t;
endpackage
